// ==== tmr_pkg.sv ====
package tmr_pkg;
   localparam int          CNT_W         = 8;
   localparam logic [7:0]  BOTTOM_VAL    = 8'h00;
   localparam logic [7:0]  MAX_VAL       = 8'hff;
   localparam logic [7:0]  COUNT_RST     = 8'h00;
   localparam logic [7:0]  COMPARE_RST   = 8'h00;
   localparam logic [2:0]  WAVE_NORMAL   = 3'h0;
   localparam logic [2:0]  WAVE_PC_MAX   = 3'h1;
   localparam logic [2:0]  WAVE_CTC      = 3'h2;
   localparam logic [2:0]  WAVE_FAST_MAX = 3'h3;
   localparam logic [2:0]  WAVE_PC_A     = 3'h5;
   localparam logic [2:0]  WAVE_FAST_A   = 3'h7;
   localparam logic [2:0]  SRC_STOP      = 3'h0;
   localparam logic [2:0]  SRC_DIV1      = 3'h1;
   localparam logic [2:0]  SRC_DIV8      = 3'h2;
   localparam logic [2:0]  SRC_DIV64     = 3'h3;
   localparam logic [2:0]  SRC_DIV256    = 3'h4;
   localparam logic [2:0]  SRC_DIV1024   = 3'h5;
   localparam logic [2:0]  SRC_EXT_FALL  = 3'h6;
   localparam logic [2:0]  SRC_EXT_RISE  = 3'h7;
   localparam logic [9:0]  DIV8_MASK     = 10'h007;
   localparam logic [9:0]  DIV64_MASK    = 10'h03f;
   localparam logic [9:0]  DIV256_MASK   = 10'h0ff;
   localparam logic [9:0]  DIV1024_MASK  = 10'h3ff;
   localparam logic [9:0]  PRESCALE_RST  = 10'h000;
   localparam logic [1:0]  ACT_NONE      = 2'h0;
   localparam logic [1:0]  ACT_TOGGLE    = 2'h1;
   localparam logic [1:0]  ACT_CLEAR     = 2'h2;
   localparam logic [1:0]  ACT_SET       = 2'h3;

   typedef struct packed {
      logic       wr;
      logic [7:0] data;
   } tmr_write_type;

   typedef struct packed {
      logic [1:0] output_action;
      logic       force_match_strobe;
      logic       int_enable;
      logic       flag_clear;
   } tmr_chan_ctl_type;
endpackage

// ==== tmr_compare_unit.sv ====
`timescale 1ns/1ps
module tmr_compare_unit (
   input  wire logic                   clock_i,
   input  wire logic                   rst_n_i,
   input  wire tmr_pkg::tmr_write_type wr_i,
   input  wire logic                   buffered_i,
   input  wire logic                   update_i,
   output logic [7:0]                  active_o,
   output logic [7:0]                  readback_o
);
   logic [7:0] buffer_r;
   logic [7:0] active_r;
   logic [7:0] buffer_nxt;
   logic [7:0] active_nxt;

   // writes land in the buffer in pwm modes, straight in otherwise
   assign buffer_nxt = wr_i.wr ? wr_i.data : buffer_r;
   assign active_nxt = (!buffered_i && wr_i.wr) ? wr_i.data :
                       (buffered_i && update_i) ? buffer_r : active_r;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         buffer_r <= tmr_pkg::COMPARE_RST;
         active_r <= tmr_pkg::COMPARE_RST;
      end else begin
         buffer_r <= buffer_nxt;
         active_r <= active_nxt;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         readback_o <= tmr_pkg::COMPARE_RST;
      end else begin
         readback_o <= buffered_i ? buffer_nxt : active_nxt;
      end
   end

   assign active_o = active_r;
endmodule // tmr_compare_unit

// ==== tmr_timer8.sv ====
`timescale 1ns/1ps
module tmr_timer8 (
   input  wire logic                      clock_i,
   input  wire logic                      rst_n_i,
   input  wire logic [2:0]                tick_source_select_i,
   input  wire logic [2:0]                wave_mode_i,
   input  wire logic                      ext_tick_pin_i,
   input  wire tmr_pkg::tmr_write_type    count_wr_i,
   input  wire tmr_pkg::tmr_write_type    compare_a_wr_i,
   input  wire tmr_pkg::tmr_write_type    compare_b_wr_i,
   input  wire tmr_pkg::tmr_chan_ctl_type chan_a_i,
   input  wire tmr_pkg::tmr_chan_ctl_type chan_b_i,
   input  wire logic                      ovf_int_enable_i,
   input  wire logic                      ovf_flag_clear_i,
   input  wire logic                      ovf_int_ack_i,
   input  wire logic                      a_int_ack_i,
   input  wire logic                      b_int_ack_i,
   input  wire logic                      port_out_a_i,
   input  wire logic                      port_out_b_i,
   input  wire logic                      port_dir_a_i,
   input  wire logic                      port_dir_b_i,
   output logic [7:0]                     count_value_o,
   output logic [7:0]                     compare_reg_a_o,
   output logic [7:0]                     compare_reg_b_o,
   output logic                           overflow_flag_o,
   output logic                           match_flag_a_o,
   output logic                           match_flag_b_o,
   output logic                           ovf_irq_o,
   output logic                           a_irq_o,
   output logic                           b_irq_o,
   output logic                           compare_output_a_o,
   output logic                           compare_output_b_o,
   output logic                           pin_a_o,
   output logic                           pin_b_o,
   output logic                           pin_a_oe_n_o,
   output logic                           pin_b_oe_n_o
);
   typedef enum logic [1:0] {
      DIR_UP   = 2'b01,
      DIR_DOWN = 2'b10
   } tmr_dir_type;

   logic [7:0]  count_r;
   logic [7:0]  count_nxt;
   logic [9:0]  prescale_r;
   logic        ext_meta_r;
   logic        ext_sync_r;
   logic        ext_prev_r;
   logic        block_r;
   logic        ovf_r;
   logic        flag_a_r;
   logic        flag_b_r;
   logic        latch_a_r;
   logic        latch_b_r;
   logic        latch_a_nxt;
   logic        latch_b_nxt;
   tmr_dir_type dir_r;
   tmr_dir_type dir_nxt;
   logic [7:0]  cmp_a;
   logic [7:0]  cmp_b;

   function automatic logic apply_action(input logic [1:0] act,
                                         input logic       cur,
                                         input logic       up);
      case (act)
         tmr_pkg::ACT_TOGGLE: apply_action = ~cur;
         tmr_pkg::ACT_CLEAR:  apply_action = ~up;
         tmr_pkg::ACT_SET:    apply_action = up;
         default:             apply_action = cur;
      endcase
   endfunction

   // mode decode
   wire mode_fast  = (wave_mode_i == tmr_pkg::WAVE_FAST_MAX) ||
                     (wave_mode_i == tmr_pkg::WAVE_FAST_A);
   wire mode_pc    = (wave_mode_i == tmr_pkg::WAVE_PC_MAX) ||
                     (wave_mode_i == tmr_pkg::WAVE_PC_A);
   wire mode_pwm   = mode_fast || mode_pc;
   wire mode_ctc   = (wave_mode_i == tmr_pkg::WAVE_CTC);
   wire top_is_a   = (wave_mode_i == tmr_pkg::WAVE_FAST_A) ||
                     (wave_mode_i == tmr_pkg::WAVE_PC_A) || mode_ctc;
   wire [7:0] top_val = top_is_a ? cmp_a : tmr_pkg::MAX_VAL;

   // tick generation; external pin synchronised first
   wire ext_rise = ext_sync_r & ~ext_prev_r;
   wire ext_fall = ~ext_sync_r & ext_prev_r;
   logic timer_tick;
   always_comb begin
      case (tick_source_select_i)
         tmr_pkg::SRC_DIV1:     timer_tick = 1'b1;
         tmr_pkg::SRC_DIV8:
            timer_tick = (prescale_r & tmr_pkg::DIV8_MASK) == 10'h000;
         tmr_pkg::SRC_DIV64:
            timer_tick = (prescale_r & tmr_pkg::DIV64_MASK) == 10'h000;
         tmr_pkg::SRC_DIV256:
            timer_tick = (prescale_r & tmr_pkg::DIV256_MASK) == 10'h000;
         tmr_pkg::SRC_DIV1024:
            timer_tick = (prescale_r & tmr_pkg::DIV1024_MASK) == 10'h000;
         tmr_pkg::SRC_EXT_FALL: timer_tick = ext_fall;
         tmr_pkg::SRC_EXT_RISE: timer_tick = ext_rise;
         default:               timer_tick = 1'b0;
      endcase
   end

   // comparator; blocked for one tick after a count write
   wire match_a = (count_r == cmp_a) && !block_r;
   wire match_b = (count_r == cmp_b) && !block_r;
   wire at_top    = (count_r == top_val);
   wire at_bottom = (count_r == tmr_pkg::BOTTOM_VAL);
   wire going_up  = (dir_r == DIR_UP);

   // counting sequence
   always_comb begin
      count_nxt = count_r;
      dir_nxt   = dir_r;
      if (timer_tick) begin
         if (mode_pc) begin
            if (going_up && at_top) begin
               dir_nxt   = DIR_DOWN;
               count_nxt = count_r - 8'h01;
            end else if (!going_up && at_bottom) begin
               dir_nxt   = DIR_UP;
               count_nxt = count_r + 8'h01;
            end else begin
               count_nxt = going_up ? count_r + 8'h01 : count_r - 8'h01;
            end
         end else if ((mode_ctc || mode_fast) && at_top) begin
            count_nxt = tmr_pkg::BOTTOM_VAL;
            dir_nxt   = DIR_UP;
         end else begin
            // past a low top the count simply wraps
            count_nxt = count_r + 8'h01;
            dir_nxt   = DIR_UP;
         end
      end
      if (count_wr_i.wr) begin
         count_nxt = count_wr_i.data;
      end
   end

   // overflow: at wrap to 0x00 in normal/ctc, top in fast, bottom in pc
   wire ovf_event = timer_tick && !count_wr_i.wr &&
                    (mode_pc ? (!going_up && at_bottom) :
                     mode_fast ? at_top :
                     (count_r == tmr_pkg::MAX_VAL));
   // in ctc a match on a doubles as the clear, flag still sets
   wire set_a = timer_tick && match_a;
   wire set_b = timer_tick && match_b;

   // double buffer update: fast pwm at top, phase correct at top
   wire cmp_update = timer_tick &&
                     (mode_fast ? at_top : (going_up && at_top));

   // output latch; action applied at match, or at force strobe outside pwm modes
   wire force_a = chan_a_i.force_match_strobe && !mode_pwm;
   wire force_b = chan_b_i.force_match_strobe && !mode_pwm;
   // pwm "up" means match drives inactive level; set pattern flips on
   // the down slope or at the bottom restart
   wire pc_lvl = mode_pc ? !going_up : 1'b0;
   wire restart = timer_tick && mode_fast && at_top;
   wire nonpwm_set = 1'b1;

   // channel b has no toggle in pwm modes
   wire [1:0] act_b = (mode_pwm && chan_b_i.output_action ==
                       tmr_pkg::ACT_TOGGLE) ? tmr_pkg::ACT_NONE :
                      chan_b_i.output_action;
   wire a_tog_ok = !mode_pwm || wave_mode_i[2];
   wire [1:0] act_a = (chan_a_i.output_action == tmr_pkg::ACT_TOGGLE &&
                       !a_tog_ok) ? tmr_pkg::ACT_NONE :
                      chan_a_i.output_action;

   function automatic logic pwm_pol(input logic [1:0] act,
                                    input logic       lvl);
      pwm_pol = (act == tmr_pkg::ACT_SET) ? ~lvl : lvl;
   endfunction

   always_comb begin
      latch_a_nxt = latch_a_r;
      if (mode_pwm && act_a[1]) begin
         if (set_a) begin
            latch_a_nxt = pwm_pol(act_a, pc_lvl);
         end else if (restart) begin
            latch_a_nxt = pwm_pol(act_a, 1'b1);
         end
      end else if (set_a || force_a) begin
         latch_a_nxt = apply_action(act_a, latch_a_r, nonpwm_set);
      end
   end

   always_comb begin
      latch_b_nxt = latch_b_r;
      if (mode_pwm && act_b[1]) begin
         if (set_b) begin
            latch_b_nxt = pwm_pol(act_b, pc_lvl);
         end else if (restart) begin
            latch_b_nxt = pwm_pol(act_b, 1'b1);
         end
      end else if (set_b || force_b) begin
         latch_b_nxt = apply_action(act_b, latch_b_r, nonpwm_set);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         count_r    <= tmr_pkg::COUNT_RST;
         dir_r      <= DIR_UP;
         prescale_r <= tmr_pkg::PRESCALE_RST;
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
         ext_prev_r <= 1'b0;
         block_r    <= 1'b0;
         latch_a_r  <= 1'b0;
         latch_b_r  <= 1'b0;
      end else begin
         count_r    <= count_nxt;
         dir_r      <= dir_nxt;
         prescale_r <= prescale_r + 10'h001;
         ext_meta_r <= ext_tick_pin_i;
         ext_sync_r <= ext_meta_r;
         ext_prev_r <= ext_sync_r;
         // block holds from the write until the next tick passes
         block_r    <= count_wr_i.wr ? 1'b1 : (timer_tick ? 1'b0 : block_r);
         latch_a_r  <= latch_a_nxt;
         latch_b_r  <= latch_b_nxt;
      end
   end

   // flags: set wins over clear
   wire clr_a   = chan_a_i.flag_clear || a_int_ack_i;
   wire clr_b   = chan_b_i.flag_clear || b_int_ack_i;
   wire clr_ovf = ovf_flag_clear_i || ovf_int_ack_i;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ovf_r    <= 1'b0;
         flag_a_r <= 1'b0;
         flag_b_r <= 1'b0;
      end else begin
         ovf_r    <= ovf_event | (ovf_r & ~clr_ovf);
         flag_a_r <= set_a | (flag_a_r & ~clr_a);
         flag_b_r <= set_b | (flag_b_r & ~clr_b);
      end
   end

   tmr_compare_unit u_cmp_a (
      .clock_i    (clock_i),
      .rst_n_i    (rst_n_i),
      .wr_i       (compare_a_wr_i),
      .buffered_i (mode_pwm),
      .update_i   (cmp_update),
      .active_o   (cmp_a),
      .readback_o (compare_reg_a_o)
   );

   tmr_compare_unit u_cmp_b (
      .clock_i    (clock_i),
      .rst_n_i    (rst_n_i),
      .wr_i       (compare_b_wr_i),
      .buffered_i (mode_pwm),
      .update_i   (cmp_update),
      .active_o   (cmp_b),
      .readback_o (compare_reg_b_o)
   );

   assign count_value_o      = count_r;
   assign overflow_flag_o    = ovf_r;
   assign match_flag_a_o     = flag_a_r;
   assign match_flag_b_o     = flag_b_r;
   assign ovf_irq_o          = ovf_r & ovf_int_enable_i;
   assign a_irq_o            = flag_a_r & chan_a_i.int_enable;
   assign b_irq_o            = flag_b_r & chan_b_i.int_enable;
   assign compare_output_a_o = latch_a_r;
   assign compare_output_b_o = latch_b_r;
   // override of the port by the latch, direction stays with port
   assign pin_a_o      = (|chan_a_i.output_action) ? latch_a_r : port_out_a_i;
   assign pin_b_o      = (|chan_b_i.output_action) ? latch_b_r : port_out_b_i;
   assign pin_a_oe_n_o = ~port_dir_a_i;
   assign pin_b_oe_n_o = ~port_dir_b_i;
endmodule // tmr_timer8

// ==== tmr_timer8_assertions.sv ====
`timescale 1ns/1ps
module tmr_timer8_assertions (
   input wire logic                      clock_i,
   input wire logic                      rst_n_i,
   input wire logic [2:0]                tick_source_select_i,
   input wire logic [2:0]                wave_mode_i,
   input wire tmr_pkg::tmr_write_type    count_wr_i,
   input wire tmr_pkg::tmr_chan_ctl_type chan_a_i,
   input wire logic                      a_int_ack_i,
   input wire logic                      port_out_a_i,
   input wire logic                      port_dir_a_i,
   input wire logic [7:0]                count_value_o,
   input wire logic [7:0]                compare_reg_a_o,
   input wire logic [7:0]                compare_reg_b_o,
   input wire logic                      overflow_flag_o,
   input wire logic                      match_flag_a_o,
   input wire logic                      match_flag_b_o,
   input wire logic                      a_irq_o,
   input wire logic                      compare_output_a_o,
   input wire logic                      pin_a_o,
   input wire logic                      pin_a_oe_n_o
);
   logic blocked_r;
   logic blocked_nxt;
   logic run1;
   logic normal1;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // only a div1 cycle is surely a tick, so slower sources stay blocked
   assign blocked_nxt = count_wr_i.wr |
                        (blocked_r & !run1);
   assign run1 = (tick_source_select_i == tmr_pkg::SRC_DIV1);
   assign normal1 = run1 && (wave_mode_i == tmr_pkg::WAVE_NORMAL);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) blocked_r <= 1'b0;
      else blocked_r <= blocked_nxt;
   end

   AST_STOP_HOLD: assert property (
      (tick_source_select_i == tmr_pkg::SRC_STOP && !count_wr_i.wr)
      |=> $stable(count_value_o)) else $error("count moved while stopped");
   AST_WRITE_WINS: assert property (
      count_wr_i.wr |=> count_value_o == $past(count_wr_i.data))
      else $error("count write lost");
   AST_NORMAL_INC: assert property (
      (normal1 && !count_wr_i.wr)
      |=> count_value_o == $past(count_value_o) + 8'h01)
      else $error("normal mode did not increment");
   AST_OVF_SET: assert property (
      (normal1 && !count_wr_i.wr && count_value_o == tmr_pkg::MAX_VAL)
      |=> overflow_flag_o && count_value_o == tmr_pkg::BOTTOM_VAL)
      else $error("overflow flag not set on wrap");
   AST_CTC_CLEAR: assert property (
      (run1 && wave_mode_i == tmr_pkg::WAVE_CTC && !count_wr_i.wr &&
       !blocked_r && count_value_o == compare_reg_a_o)
      |=> count_value_o == tmr_pkg::BOTTOM_VAL)
      else $error("clear on match missing");
   AST_MATCH_B: assert property (
      (normal1 && !count_wr_i.wr && !blocked_r &&
       count_value_o == compare_reg_b_o) |=> match_flag_b_o)
      else $error("match flag b not set");
   AST_IRQ_A: assert property (
      a_irq_o == (match_flag_a_o & chan_a_i.int_enable))
      else $error("irq a wrong");
   AST_PIN_A: assert property (
      pin_a_oe_n_o == !port_dir_a_i && pin_a_o ==
      ((chan_a_i.output_action != tmr_pkg::ACT_NONE) ?
       compare_output_a_o : port_out_a_i)) else $error("pin a wrong");
   AST_NONE_HOLD: assert property (
      chan_a_i.output_action == tmr_pkg::ACT_NONE
      |=> $stable(compare_output_a_o)) else $error("latch a moved");
   AST_FORCE_A: assert property (
      (wave_mode_i == tmr_pkg::WAVE_NORMAL && chan_a_i.force_match_strobe
       && chan_a_i.output_action == tmr_pkg::ACT_SET)
      |=> compare_output_a_o) else $error("force set failed");
   AST_FLAG_CLR: assert property (
      (tick_source_select_i == tmr_pkg::SRC_STOP &&
       (chan_a_i.flag_clear || a_int_ack_i)) |=> !match_flag_a_o)
      else $error("flag a not cleared");
endmodule // tmr_timer8_assertions

bind tmr_timer8 tmr_timer8_assertions u_chk (
   .clock_i(clock_i), .rst_n_i(rst_n_i),
   .tick_source_select_i(tick_source_select_i), .wave_mode_i(wave_mode_i),
   .count_wr_i(count_wr_i), .chan_a_i(chan_a_i), .a_int_ack_i(a_int_ack_i),
   .port_out_a_i(port_out_a_i), .port_dir_a_i(port_dir_a_i),
   .count_value_o(count_value_o), .compare_reg_a_o(compare_reg_a_o),
   .compare_reg_b_o(compare_reg_b_o), .overflow_flag_o(overflow_flag_o),
   .match_flag_a_o(match_flag_a_o), .match_flag_b_o(match_flag_b_o),
   .a_irq_o(a_irq_o), .compare_output_a_o(compare_output_a_o),
   .pin_a_o(pin_a_o), .pin_a_oe_n_o(pin_a_oe_n_o));

// ==== tmr_timer8_tb.sv ====
`timescale 1ns/1ps
module tmr_timer8_tb;
   logic                      clock_i, rst_n_i, ext_pin;
   logic [2:0]                src, wave;
   tmr_pkg::tmr_write_type    cnt_wr, cmp_a_wr, cmp_b_wr;
   tmr_pkg::tmr_chan_ctl_type ch_a, ch_b;
   logic                      ovf_en, ovf_clr, ovf_ack, a_ack, b_ack;
   logic                      pout_a, pout_b, dir_a, dir_b;
   logic [7:0]                count, cmp_a_rd, cmp_b_rd;
   logic                      ovf_f, fa, fb, ovf_irq, a_irq, b_irq;
   logic                      lat_a, lat_b, pin_a, pin_b, oe_a_n, oe_b_n;
   int                        errors, checks_done;

   tmr_timer8 dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .tick_source_select_i(src),
      .wave_mode_i(wave), .ext_tick_pin_i(ext_pin), .count_wr_i(cnt_wr),
      .compare_a_wr_i(cmp_a_wr), .compare_b_wr_i(cmp_b_wr),
      .chan_a_i(ch_a), .chan_b_i(ch_b), .ovf_int_enable_i(ovf_en),
      .ovf_flag_clear_i(ovf_clr), .ovf_int_ack_i(ovf_ack),
      .a_int_ack_i(a_ack), .b_int_ack_i(b_ack), .port_out_a_i(pout_a),
      .port_out_b_i(pout_b), .port_dir_a_i(dir_a), .port_dir_b_i(dir_b),
      .count_value_o(count), .compare_reg_a_o(cmp_a_rd),
      .compare_reg_b_o(cmp_b_rd), .overflow_flag_o(ovf_f),
      .match_flag_a_o(fa), .match_flag_b_o(fb), .ovf_irq_o(ovf_irq),
      .a_irq_o(a_irq), .b_irq_o(b_irq), .compare_output_a_o(lat_a),
      .compare_output_b_o(lat_b), .pin_a_o(pin_a), .pin_b_o(pin_b),
      .pin_a_oe_n_o(oe_a_n), .pin_b_oe_n_o(oe_b_n));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask

   task automatic wr_cnt(input logic [7:0] d);
      cnt_wr = '{1'b1, d};
      cyc(1);
      cnt_wr.wr = 1'b0;
   endtask

   task automatic wr_cmp(input logic b, input logic [7:0] d);
      if (b) cmp_b_wr = '{1'b1, d};
      else cmp_a_wr = '{1'b1, d};
      cyc(1);
      cmp_a_wr.wr = 1'b0;
      cmp_b_wr.wr = 1'b0;
   endtask

   // counts cycles until the count moves; bounded above the slowest tick
   task automatic wait_step(output int n);
      logic [7:0] c;
      c = count;
      n = 0;
      while (count === c && n < 1100) begin
         cyc(1);
         n++;
      end
   endtask

   task automatic t_reset;
      check(count, 8'h00);
      check({ovf_f, fa, fb, lat_a, lat_b}, 5'h00);
      check({pin_b, oe_b_n}, {pout_b, ~dir_b});
   endtask

   task automatic t_stop;
      wr_cnt(8'h5a);
      check(count, 8'h5a);
      cyc(10);
      check(count, 8'h5a);
   endtask

   task automatic t_normal;
      wr_cnt(8'hfe);
      src = tmr_pkg::SRC_DIV1;
      cyc(1);
      check({count, ovf_f}, {8'hff, 1'b0});
      cyc(1);
      src = tmr_pkg::SRC_STOP;
      check({count, ovf_f}, {8'h00, 1'b1});
      ovf_en = 1'b1;
      cyc(1);
      check(ovf_irq, 1'b1);
      ovf_clr = 1'b1;
      cyc(1);
      ovf_clr = 1'b0;
      check(ovf_f, 1'b0);
   endtask

   task automatic t_match;
      wr_cmp(1'b0, 8'h10);
      check(cmp_a_rd, 8'h10);
      wr_cnt(8'h0e);
      ch_a.int_enable = 1'b1;
      src = tmr_pkg::SRC_DIV1;
      cyc(2);
      check({count, fa}, {8'h10, 1'b0});
      cyc(1);
      src = tmr_pkg::SRC_STOP;
      check({fa, a_irq}, 2'h3);
      a_ack = 1'b1;
      cyc(1);
      a_ack = 1'b0;
      check({fa, a_irq}, 2'h0);
   endtask

   task automatic t_block;
      ch_b.int_enable = 1'b1;
      wr_cmp(1'b1, 8'h20);
      check(cmp_b_rd, 8'h20);
      wr_cnt(8'h20);
      src = tmr_pkg::SRC_DIV1;
      cyc(1);
      src = tmr_pkg::SRC_STOP;
      check({count, fb}, {8'h21, 1'b0});
      wr_cnt(8'h1f);
      src = tmr_pkg::SRC_DIV1;
      cyc(2);
      src = tmr_pkg::SRC_STOP;
      check({fb, b_irq}, 2'h3);
      ch_b.flag_clear = 1'b1;
      cyc(1);
      ch_b.flag_clear = 1'b0;
      check(fb, 1'b0);
   endtask

   // the mode 3 entry shows the strobe ignored and the latch kept
   task automatic t_force;
      logic [1:0] act [6] = '{2'h3, 2'h0, 2'h2, 2'h1, 2'h2, 2'h1};
      logic [2:0] wv [6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h0};
      logic       exp [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      dir_a = 1'b1;
      // strobe held high: one force per cycle, never dropped and raised
      // in the same step
      ch_a.force_match_strobe = 1'b1;
      for (int i = 0; i < 6; i++) begin
         wave = wv[i];
         ch_a.output_action = act[i];
         cyc(1);
         check({lat_a, fa}, {exp[i], 1'b0});
         check(pin_a, (act[i] != 2'h0) ? exp[i] : pout_a);
      end
      ch_a.force_match_strobe = 1'b0;
      check(oe_a_n, 1'b0);
      dir_a = 1'b0;
      cyc(1);
      check(oe_a_n, 1'b1);
   endtask

   task automatic t_ctc;
      wave = tmr_pkg::WAVE_CTC;
      wr_cmp(1'b0, 8'h03);
      wr_cnt(8'h00);
      src = tmr_pkg::SRC_DIV1;
      for (int k = 1; k <= 8; k++) begin
         cyc(1);
         check(count, 16'(k % 4));
         check(lat_a, 16'((k / 4) % 2));
      end
      src = tmr_pkg::SRC_STOP;
   endtask

   task automatic t_wrap;
      int n;
      wr_cmp(1'b0, 8'h02);
      wr_cnt(8'h05);
      src = tmr_pkg::SRC_DIV1;
      n = 0;
      while (count !== 8'h00 && n < 300) begin
         cyc(1);
         n++;
      end
      src = tmr_pkg::SRC_STOP;
      check(16'(n), 16'h00fb);
      check(ovf_f, 1'b1);
      ovf_ack = 1'b1;
      cyc(1);
      ovf_ack = 1'b0;
      check(ovf_f, 1'b0);
   endtask

   task automatic t_prescale;
      logic [15:0] per [4] = '{16'h0008, 16'h0040, 16'h0100, 16'h0400};
      int          n;
      wave = tmr_pkg::WAVE_NORMAL;
      for (int s = 2; s <= 5; s++) begin
         src = 3'(s);
         wait_step(n);
         wait_step(n);
         check(16'(n), per[s - 2]);
      end
      src = tmr_pkg::SRC_STOP;
      wr_cnt(8'h00);
      for (int s = 7; s >= 6; s--) begin
         src = 3'(s);
         repeat (8) begin
            ext_pin = ~ext_pin;
            cyc(4);
         end
         cyc(2);
         check(count, 16'(4 * (9 - s) - 4));
      end
   endtask

   // fast pwm: new compare b waits in the buffer until the top restart
   task automatic t_pwm;
      int n;
      src = tmr_pkg::SRC_STOP;
      wave = tmr_pkg::WAVE_FAST_MAX;
      wr_cmp(1'b1, 8'h05);
      check(cmp_b_rd, 8'h05);
      ch_b.flag_clear = 1'b1;
      wr_cnt(8'h03);
      ch_b.flag_clear = 1'b0;
      src = tmr_pkg::SRC_DIV1;
      cyc(4);
      check({count, fb}, {8'h07, 1'b0});
      n = 0;
      while (count !== 8'h06 && n < 300) begin
         cyc(1);
         n++;
      end
      src = tmr_pkg::SRC_STOP;
      wave = tmr_pkg::WAVE_PC_A;
      check(16'(n), 16'h00ff);
      check({fb, cmp_b_rd}, {1'b1, 8'h05});
      wr_cnt(8'h00);
      src = tmr_pkg::SRC_DIV1;
      cyc(3);
      src = tmr_pkg::SRC_STOP;
      wave = tmr_pkg::WAVE_NORMAL;
      check(count, 8'h01);
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   initial begin
      #100000;
      errors++;
      stop_test;
   end

   initial begin
      {rst_n_i, ext_pin, ovf_en, ovf_clr, ovf_ack, a_ack, b_ack} = '0;
      {cnt_wr, cmp_a_wr, cmp_b_wr, ch_a, ch_b} = '0;
      {pout_a, dir_a, pout_b, dir_b} = 4'h2;
      src = tmr_pkg::SRC_STOP;
      wave = tmr_pkg::WAVE_NORMAL;
      errors = 0;
      checks_done = 0;
      cyc(6);
      rst_n_i = 1'b1;
      cyc(1);
      t_reset;
      t_stop;
      t_normal;
      t_match;
      t_block;
      t_force;
      t_ctc;
      t_wrap;
      t_prescale;
      t_pwm;
      stop_test;
   end
endmodule // tmr_timer8_tb
